// [hdl/ccpo_pkg.sv]
package ccpo_pkg;
    // ==========================================================
    // register map (word index = byte address, 16-bit data)
    localparam logic [3:0] ADDR_CTRL1    = 4'h0;  // capture control
    localparam logic [3:0] ADDR_OUTCTL   = 4'h1;  // pwm_output_control_high
    localparam logic [3:0] ADDR_TB_LO    = 4'h2;  // timebase_count_regs low
    localparam logic [3:0] ADDR_TB_HI    = 4'h3;  // timebase_count_regs high
    localparam logic [3:0] ADDR_FIFO_LO  = 4'h4;  // capture fifo low, no pop
    localparam logic [3:0] ADDR_FIFO_HI  = 4'h5;  // capture fifo high, pops
    localparam logic [3:0] ADDR_STATUS   = 4'h6;  // sticky events
    localparam logic [3:0] ADDR_IRQ_EN   = 4'h7;
    localparam logic [3:0] ADDR_IRQ_CLR  = 4'h8;
    localparam logic [3:0] ADDR_FIFO_LVL = 4'h9;
    localparam logic [3:0] ADDR_CMD      = 4'hA;  // write: bit0 trigger, bit1 shutdown

    // control register 1 fields
    localparam int MODE_LSB     = 0;
    localparam int CAP_SEL_BIT  = 4;
    localparam int WIDE_BIT     = 5;
    localparam int TRIGGERED_OPERATION_BIT   = 6;
    localparam int TSRC_BIT     = 7;   // 1: internal trigger is capture source
    localparam logic [15:0] CTRL1_MASK = 16'h00FF;

    // output control fields
    localparam int OUTPUT_GATE_UNTIL_TRIGGER_BIT   = 15;
    localparam int ONE_SHOT_EXTEND_COUNT_LSB    = 12;
    localparam int OUTPUT_MODE_FIELD_LSB     = 8;
    localparam int POLA_BIT     = 5;
    localparam int POLB_BIT     = 4;
    localparam int PSSA_LSB     = 2;
    localparam int PSSB_LSB     = 0;
    localparam logic [15:0] OUTCTL_MASK_MULTI  = 16'hF73F;
    localparam logic [15:0] OUTCTL_MASK_SINGLE = 16'hF02C;

    // status bits
    localparam int ST_CAPTURE  = 0;
    localparam int ST_OVERFLOW = 1;
    localparam int ST_SHUTDOWN = 2;

    // capture modes
    localparam logic [3:0] MODE_ANY   = 4'h0;
    localparam logic [3:0] MODE_RISE  = 4'h1;
    localparam logic [3:0] MODE_FALL  = 4'h2;
    localparam logic [3:0] MODE_BOTH  = 4'h3;
    localparam logic [3:0] MODE_RISE4 = 4'h4;
    localparam logic [3:0] MODE_RISE16 = 4'h5;
    localparam logic [3:0] PRESC4_LAST  = 4'h3;
    localparam logic [3:0] PRESC16_LAST = 4'hF;

    // shutdown state encodings
    localparam logic [1:0] SHUT_ACTIVE   = 2'h3;
    localparam logic [1:0] SHUT_INACTIVE = 2'h2;

    localparam logic [2:0] OUTPUT_MODE_FIELD_RSVD3 = 3'h3;
    localparam logic [2:0] OUTPUT_MODE_FIELD_RSVD7 = 3'h7;
endpackage

// [hdl/ccpo_sync.sv]
// ==========================================================
// two-flop synchroniser for pin inputs
module ccpo_sync
(
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic din,
    output logic      dout
);
    logic meta_q;
    logic meta_d;
    logic dout_d;

    // first flop feeds only the second
    always_comb
    begin
        meta_d = din;
        dout_d = meta_q;
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            meta_q <= 1'b0;
            dout   <= 1'b0;
        end
        else
        begin
            meta_q <= meta_d;
            dout   <= dout_d;
        end
    end
endmodule

// [hdl/ccpo_fifo.sv]
// ==========================================================
// capture fifo; a push when full is dropped and flagged
module ccpo_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
)
(
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic             pop,
    output logic      [WIDTH-1:0] rdata,
    output logic                  empty,
    output logic                  full,
    output logic      [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wp_q;
    logic [AW:0]      wp_d;
    logic [AW:0]      rp_q;
    logic [AW:0]      rp_d;
    logic             do_push;
    logic             do_pop;

    // pointers one bit wider than the address tell full from empty
    always_comb
    begin
        empty   = wp_q == rp_q;
        full    = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
        do_push = push && !full;
        do_pop  = pop && !empty;
        wp_d    = do_push ? wp_q + 1'b1 : wp_q;
        rp_d    = do_pop ? rp_q + 1'b1 : rp_q;
        level   = wp_q - rp_q;
        rdata   = mem_q[rp_q[AW-1:0]];
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            wp_q <= '0;
            rp_q <= '0;
        end
        else
        begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (do_push)
            mem_q[wp_q[AW-1:0]] <= wdata;
    end
endmodule

// [hdl/ccpo_top.sv]
// How it works
// R1 - dedicated up counter, 16 or 32 bits
// R2 - capture from pin or internal trigger
// R3 - each capture pushes timebase into fifo
// R4 - capture only while capture_select bit4 set
// R5 - mode field plus width bit pick behaviour
// R6 - codes 0-3: any, rise, fall, both edges
// R7 - code 4 every 4th, 5 every 16th rise
// R8 - width bit picks 32 or 16 bit values
// R9 - timebase readable after synchronising delay
// R10 - gate bit holds pins undriven until trigger; here only in triggered operation (ctrl1 bit6), from an output control write on
// R11 - one-shot lasts N+1 timebase periods
// R12 - output mode field selects drive mode
// R13 - mode, group B fields multi-variant only
// R14 - per group polarity after waveform
// R15 - shutdown state per group two-bit field
//
// Chosen here: the placing of the registers and strobed register access.
module ccpo_top #(
    parameter bit MULTI_OUTPUT = 1'b1,  // multi_output_variant
    parameter int FIFO_DEPTH   = 4
)
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    input  wire logic        cap_pin,
    input  wire logic        trig_in,
    input  wire logic        shutdown_in,
    output logic      [2:0]  out_a_o,
    output logic      [2:0]  out_a_oe,
    output logic      [2:0]  out_b_o,
    output logic      [2:0]  out_b_oe,
    output logic             irq
);
    // ==========================================================
    // register bus
    logic [15:0] ctrl1_q, ctrl1_d, outctl_q, outctl_d, rdata_d;
    logic [2:0]  status_q, status_d, irq_en_q, irq_en_d;
    logic        irq_d;
    logic [31:0] tb_q, tb_d, tb_view_q, tb_view_d;
    logic        pin_s, pin_prev_q, trig_s, trig_prev_q, shut_s, shut_prev_q;
    logic [3:0]  presc_q, presc_d;
    logic        rise, fall, trig_ev, shut_ev, sw_trig, sw_shut;
    logic        cap_ev, wide, capture_on, ext_trig;
    logic [31:0] fifo_rd;
    logic        fifo_empty, fifo_full, fifo_pop;
    logic [$clog2(FIFO_DEPTH):0] fifo_lvl;
    logic [2:0]  os_cnt_q, os_cnt_d;
    logic        os_run_q, os_run_d, armed_q, armed_d, shut_q, shut_d;
    logic [2:0]  a_o_d, a_oe_d, b_o_d, b_oe_d;

    ccpo_sync u_sync_pin  (.mclk(mclk), .reset(reset), .din(cap_pin),     .dout(pin_s));
    ccpo_sync u_sync_trig (.mclk(mclk), .reset(reset), .din(trig_in),     .dout(trig_s));
    ccpo_sync u_sync_shut (.mclk(mclk), .reset(reset), .din(shutdown_in), .dout(shut_s));

    ccpo_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk  (mclk),
        .reset (reset),
        .push  (cap_ev),
        .wdata (tb_q),
        .pop   (fifo_pop),
        .rdata (fifo_rd),
        .empty (fifo_empty),
        .full  (fifo_full),
        .level (fifo_lvl)
    );

    // mask clears unimplemented bits; single variant lacks group B and mode
    function automatic logic [15:0] outctl_mask(input bit multi);
        return multi ? ccpo_pkg::OUTCTL_MASK_MULTI : ccpo_pkg::OUTCTL_MASK_SINGLE;
    endfunction

    // ==========================================================
    // event detection and capture
    always_comb
    begin
        wide       = ctrl1_q[ccpo_pkg::WIDE_BIT];
        capture_on = ctrl1_q[ccpo_pkg::CAP_SEL_BIT];                 // see R4
        sw_trig    = wr && addr == ccpo_pkg::ADDR_CMD && wdata[0];
        sw_shut    = wr && addr == ccpo_pkg::ADDR_CMD && wdata[1];
        rise       = pin_s && !pin_prev_q;
        fall       = !pin_s && pin_prev_q;
        ext_trig   = trig_s && !trig_prev_q;
        trig_ev    = ext_trig || sw_trig;
        shut_ev    = (shut_s && !shut_prev_q) || sw_shut;
        presc_d    = presc_q;
        cap_ev     = 1'b0;
        // see R5
        if (capture_on && ctrl1_q[ccpo_pkg::TSRC_BIT])
            cap_ev = trig_ev;                                         // see R2
        else if (capture_on)
        begin
            unique case (ctrl1_q[3:0])                                // see R6
                ccpo_pkg::MODE_ANY,
                ccpo_pkg::MODE_BOTH:  cap_ev = rise || fall;
                ccpo_pkg::MODE_RISE:  cap_ev = rise;
                ccpo_pkg::MODE_FALL:  cap_ev = fall;
                ccpo_pkg::MODE_RISE4, ccpo_pkg::MODE_RISE16:          // see R7
                begin
                    if (rise)
                    begin
                        cap_ev  = presc_q == ((ctrl1_q[3:0] == ccpo_pkg::MODE_RISE4)
                                  ? ccpo_pkg::PRESC4_LAST : ccpo_pkg::PRESC16_LAST);
                        presc_d = cap_ev ? 4'h0 : presc_q + 4'h1;
                    end
                end
                default: cap_ev = 1'b0;  // codes above 5 capture nothing
            endcase
        end
        if (!capture_on)
            presc_d = 4'h0;
        // timebase counts up; 16-bit mode wraps at 16 bits     // see R1
        tb_d = capture_on ? tb_q + 32'h1 : 32'h0;
        if (!wide)
            tb_d[31:16] = 16'h0;                                       // see R8
        tb_view_d = tb_q;                                              // see R9
    end

    // ==========================================================
    // registers and sticky status; set beats clear
    always_comb
    begin
        ctrl1_d  = ctrl1_q;
        outctl_d = outctl_q;
        irq_en_d = irq_en_q;
        status_d = status_q;
        if (wr && addr == ccpo_pkg::ADDR_CTRL1)
            ctrl1_d = wdata & ccpo_pkg::CTRL1_MASK;
        if (wr && addr == ccpo_pkg::ADDR_OUTCTL)
            outctl_d = wdata & outctl_mask(MULTI_OUTPUT);            // see R13
        if (wr && addr == ccpo_pkg::ADDR_IRQ_EN)
            irq_en_d = wdata[2:0];
        if (wr && addr == ccpo_pkg::ADDR_IRQ_CLR)
            status_d = status_d & ~wdata[2:0];
        if (cap_ev)
            status_d[ccpo_pkg::ST_CAPTURE] = 1'b1;
        if (cap_ev && fifo_full)
            status_d[ccpo_pkg::ST_OVERFLOW] = 1'b1;
        if (shut_ev)
            status_d[ccpo_pkg::ST_SHUTDOWN] = 1'b1;
        irq_d    = |(status_d & irq_en_d);
        fifo_pop = rd && addr == ccpo_pkg::ADDR_FIFO_HI;              // see R3
        unique case (addr)
            ccpo_pkg::ADDR_CTRL1:    rdata_d = ctrl1_q;
            ccpo_pkg::ADDR_OUTCTL:   rdata_d = outctl_q;
            ccpo_pkg::ADDR_TB_LO:    rdata_d = tb_view_q[15:0];
            ccpo_pkg::ADDR_TB_HI:    rdata_d = tb_view_q[31:16];
            ccpo_pkg::ADDR_FIFO_LO:  rdata_d = fifo_rd[15:0];
            ccpo_pkg::ADDR_FIFO_HI:  rdata_d = fifo_rd[31:16];
            ccpo_pkg::ADDR_STATUS:   rdata_d = {12'h000, !fifo_empty, status_q};
            ccpo_pkg::ADDR_IRQ_EN:   rdata_d = {13'h0000, irq_en_q};
            ccpo_pkg::ADDR_FIFO_LVL: rdata_d = 16'(fifo_lvl);
            default:                 rdata_d = 16'h0000;
        endcase
        if (!rd)
            rdata_d = 16'h0000;
    end

    // ==========================================================
    // output control: one-shot, gating, shutdown, polarity
    always_comb
    begin
        logic       wave;
        logic [2:0] mode;
        logic       pol_a, pol_b, drive;
        wave     = 1'b0;
        drive    = 1'b0;
        mode     = outctl_q[ccpo_pkg::OUTPUT_MODE_FIELD_LSB +: 3];                  // see R12
        pol_a    = outctl_q[ccpo_pkg::POLA_BIT];
        pol_b    = outctl_q[ccpo_pkg::POLB_BIT];
        os_cnt_d = os_cnt_q;
        os_run_d = os_run_q;
        armed_d  = armed_q;
        shut_d   = shut_q;
        // one-shot stays on for N+1 timebase periods       // see R11
        if (trig_ev && !os_run_q)
        begin
            os_run_d = 1'b1;
            os_cnt_d = outctl_q[ccpo_pkg::ONE_SHOT_EXTEND_COUNT_LSB +: 3];
        end
        else if (os_run_q)
        begin
            if (os_cnt_q == 3'h0)
                os_run_d = 1'b0;
            else
                os_cnt_d = os_cnt_q - 3'h1;
        end
        wave = os_run_q;
        // triggered-mode gating holds pins undriven until a trigger  // see R10
        // next-cycle settings, so an output control write that leaves gating on also disarms
        if (!ctrl1_d[ccpo_pkg::TRIGGERED_OPERATION_BIT] || !outctl_d[ccpo_pkg::OUTPUT_GATE_UNTIL_TRIGGER_BIT])
            armed_d = 1'b1;
        else if (trig_ev)
            armed_d = 1'b1;
        else if (!os_run_q && wr && addr == ccpo_pkg::ADDR_OUTCTL)
            armed_d = 1'b0;
        if (shut_ev)
            shut_d = 1'b1;
        else if (wr && addr == ccpo_pkg::ADDR_IRQ_CLR && wdata[ccpo_pkg::ST_SHUTDOWN])
            shut_d = 1'b0;
        drive = armed_q && mode != ccpo_pkg::OUTPUT_MODE_FIELD_RSVD3 && mode != ccpo_pkg::OUTPUT_MODE_FIELD_RSVD7;
        // polarity applied after waveform          // see R14
        a_o_d  = {3{wave ^ pol_a}};
        b_o_d  = (mode == 3'h0) ? {3{pol_b}} : {3{!wave ^ pol_b}};
        a_oe_d = {3{drive}};
        b_oe_d = {3{drive && MULTI_OUTPUT}};
        if (shut_q)                                                    // see R15
        begin
            a_o_d  = {3{(outctl_q[ccpo_pkg::PSSA_LSB +: 2] == ccpo_pkg::SHUT_ACTIVE) ^ pol_a}};
            a_oe_d = {3{outctl_q[ccpo_pkg::PSSA_LSB + 1]}};
            b_o_d  = {3{(outctl_q[ccpo_pkg::PSSB_LSB +: 2] == ccpo_pkg::SHUT_ACTIVE) ^ pol_b}};
            b_oe_d = {3{outctl_q[ccpo_pkg::PSSB_LSB + 1] && MULTI_OUTPUT}};
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            ctrl1_q     <= 16'h0000;
            outctl_q    <= 16'h0000;
            status_q    <= 3'h0;
            irq_en_q    <= 3'h0;
            irq         <= 1'b0;
            rdata       <= 16'h0000;
            tb_q        <= 32'h0;
            tb_view_q   <= 32'h0;
            pin_prev_q  <= 1'b0;
            trig_prev_q <= 1'b0;
            shut_prev_q <= 1'b0;
            presc_q     <= 4'h0;
            os_cnt_q    <= 3'h0;
            os_run_q    <= 1'b0;
            armed_q     <= 1'b1;
            shut_q      <= 1'b0;
            out_a_o     <= 3'h0;
            out_a_oe    <= 3'h0;
            out_b_o     <= 3'h0;
            out_b_oe    <= 3'h0;
        end
        else
        begin
            ctrl1_q     <= ctrl1_d;
            outctl_q    <= outctl_d;
            status_q    <= status_d;
            irq_en_q    <= irq_en_d;
            irq         <= irq_d;
            rdata       <= rdata_d;
            tb_q        <= tb_d;
            tb_view_q   <= tb_view_d;
            pin_prev_q  <= pin_s;
            trig_prev_q <= trig_s;
            shut_prev_q <= shut_s;
            presc_q     <= presc_d;
            os_cnt_q    <= os_cnt_d;
            os_run_q    <= os_run_d;
            armed_q     <= armed_d;
            shut_q      <= shut_d;
            out_a_o     <= a_o_d;
            out_a_oe    <= a_oe_d;
            out_b_o     <= b_o_d;
            out_b_oe    <= b_oe_d;
        end
    end

    // ==========================================================
    // checks
    property p_cap_off; // see R4
        @(posedge mclk) disable iff (reset)
        !capture_on |-> !cap_ev;
    endproperty
    a_cap_off: assert property (p_cap_off) else $error("capture while disabled"); // see R4

    property p_push_value; // see R3
        @(posedge mclk) disable iff (reset)
        (cap_ev && fifo_empty) |=> (fifo_rd == $past(tb_q));
    endproperty
    a_push_value: assert property (p_push_value) else $error("fifo lost capture"); // see R3

    property p_narrow; // see R8
        @(posedge mclk) disable iff (reset)
        !wide |=> (tb_q[31:16] == 16'h0);
    endproperty
    a_narrow: assert property (p_narrow) else $error("narrow timebase upper set"); // see R8

    property p_count_up; // see R1
        @(posedge mclk) disable iff (reset)
        (capture_on && wide && $past(capture_on) && $past(wide)) |-> tb_q == $past(tb_q) + 32'h1;
    endproperty
    a_count_up: assert property (p_count_up) else $error("timebase not counting"); // see R1

    property p_view_lag; // see R9
        @(posedge mclk) disable iff (reset)
        1'b1 |=> tb_view_q == $past(tb_q);
    endproperty
    a_view_lag: assert property (p_view_lag) else $error("timebase view wrong"); // see R9

    property p_rise_only; // see R6
        @(posedge mclk) disable iff (reset)
        (capture_on && !ctrl1_q[ccpo_pkg::TSRC_BIT] && ctrl1_q[3:0] == ccpo_pkg::MODE_RISE)
            |-> cap_ev == rise;
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("rise mode mismatch"); // see R6

    property p_every4; // see R7
        @(posedge mclk) disable iff (reset)
        (cap_ev && capture_on && !ctrl1_q[ccpo_pkg::TSRC_BIT]
            && ctrl1_q[3:0] == ccpo_pkg::MODE_RISE4) |-> presc_q == 4'h3;
    endproperty
    a_every4: assert property (p_every4) else $error("prescaler off"); // see R7

    property p_shut_hiz; // see R15
        @(posedge mclk) disable iff (reset)
        (shut_q && !outctl_q[ccpo_pkg::PSSA_LSB + 1]) |=> out_a_oe == 3'h0;
    endproperty
    a_shut_hiz: assert property (p_shut_hiz) else $error("shutdown pins driven"); // see R15

    property p_single; // see R13
        @(posedge mclk) disable iff (reset)
        !MULTI_OUTPUT |-> (outctl_q[10:8] == 3'h0 && out_b_oe == 3'h0);
    endproperty
    a_single: assert property (p_single) else $error("group B in single variant"); // see R13
endmodule

// [test/ccpo_ext_model.sv]
// ==========================================================
// far side: capture source, trigger and shutdown sources
module ccpo_ext_model
(
    input  wire logic mclk_ref,
    output logic      cap_pin,
    output logic      trig_in,
    output logic      shutdown_in
);
    timeunit 1ns;
    timeprecision 100ps;

    // pins idle low until a task drives them
    initial
    begin
        cap_pin     = 1'b0;
        trig_in     = 1'b0;
        shutdown_in = 1'b0;
    end

    // n pulses, exactly hi and lo cycles each, so rises are hi+lo apart
    task automatic pulse(input int n, input int hi, input int lo);
        @(posedge mclk_ref);
        repeat (n)
        begin
            cap_pin <= 1'b1;
            repeat (hi) @(posedge mclk_ref);
            cap_pin <= 1'b0;
            repeat (lo) @(posedge mclk_ref);
        end
    endtask

    // rising edge then release, held 3 cycles so the sync sees it
    task automatic strobe(input bit shut);
        @(posedge mclk_ref);
        if (shut)
            shutdown_in <= 1'b1;
        else
            trig_in <= 1'b1;
        repeat (3) @(posedge mclk_ref);
        shutdown_in <= 1'b0;
        trig_in     <= 1'b0;
    endtask
endmodule

// [test/tb_top.sv]
// ==========================================================
// bench top: register bus driver and scenarios
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk  = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  addr  = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic [15:0] rdata;
    logic [2:0]  out_a_o;
    logic [2:0]  out_a_oe;
    logic [2:0]  out_b_o;
    logic [2:0]  out_b_oe;
    logic        irq;
    logic        cap_pin;
    logic        trig_in;
    logic        shutdown_in;
    int          errors      = 0;
    int          checks_done = 0;
    int          cycles      = 0;

    ccpo_ext_model u_ccpo_ext_model (
        .mclk_ref    (mclk),
        .cap_pin     (cap_pin),
        .trig_in     (trig_in),
        .shutdown_in (shutdown_in)
    );

    ccpo_top u_ccpo_top (
        .mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .cap_pin(cap_pin),
        .trig_in(trig_in), .shutdown_in(shutdown_in),
        .out_a_o(out_a_o), .out_a_oe(out_a_oe), .out_b_o(out_b_o), .out_b_oe(out_b_oe),
        .irq(irq)
    );

    always #20 mclk = ~mclk;

    // hang guard: whole run is well under a thousand cycles
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors = errors + 1;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask

    // reset values, unmapped index, output enables all on
    task automatic t_reset();
        logic [15:0] v;
        rd_reg(ccpo_pkg::ADDR_CTRL1, v);
        chk(v, 16'h0000);
        rd_reg(ccpo_pkg::ADDR_OUTCTL, v);
        chk(v, 16'h0000);
        wr_reg(4'hB, 16'hFFFF);
        rd_reg(4'hB, v);
        chk(v, 16'h0000);
        chk({10'h000, out_a_oe, out_b_oe}, 16'h003F);
        wr_reg(ccpo_pkg::ADDR_OUTCTL, 16'hFFFF);
        rd_reg(ccpo_pkg::ADDR_OUTCTL, v);
        chk(v, ccpo_pkg::OUTCTL_MASK_MULTI);
        $display("test reset done");
    endtask

    // every capture code, plus capture_select off and an unused code
    task automatic t_modes();
        logic [15:0] ctl [8] = '{16'h0010, 16'h0011, 16'h0012, 16'h0013,
                                16'h0014, 16'h0015, 16'h0001, 16'h0016};
        int          np  [8] = '{1, 1, 1, 1, 4, 16, 2, 2};
        int          ex  [8] = '{2, 1, 1, 2, 1, 1, 0, 0};
        logic [15:0] v;
        for (int i = 0; i < 8; i++)
        begin
            wr_reg(ccpo_pkg::ADDR_CTRL1, ctl[i]);
            u_ccpo_ext_model.pulse(np[i], 3, 3);
            repeat (6) @(posedge mclk);
            rd_reg(ccpo_pkg::ADDR_FIFO_LVL, v);
            chk(v, 16'(ex[i]));
            repeat (ex[i]) rd_reg(ccpo_pkg::ADDR_FIFO_HI, v);
        end
        $display("test modes done");
    endtask

    // captured stamps differ by the rise spacing; upper half empty in 16-bit
    task automatic t_stamp();
        logic [15:0] a, b, h;
        wr_reg(ccpo_pkg::ADDR_CTRL1, 16'h0011);
        u_ccpo_ext_model.pulse(2, 5, 5);
        repeat (6) @(posedge mclk);
        rd_reg(ccpo_pkg::ADDR_FIFO_LO, a);
        rd_reg(ccpo_pkg::ADDR_FIFO_HI, h);
        chk(h, 16'h0000);
        rd_reg(ccpo_pkg::ADDR_FIFO_LO, b);
        rd_reg(ccpo_pkg::ADDR_FIFO_HI, h);
        chk(b - a, 16'h000A);
        // switch to the wide count while it runs
        wr_reg(ccpo_pkg::ADDR_CTRL1, 16'h0031);
        rd_reg(ccpo_pkg::ADDR_TB_LO, a);
        rd_reg(ccpo_pkg::ADDR_TB_LO, b);
        chk(b - a, 16'h0002);
        // internal trigger as capture source, fired by software
        wr_reg(ccpo_pkg::ADDR_CTRL1, 16'h0090);
        wr_reg(ccpo_pkg::ADDR_CMD, 16'h0001);
        rd_reg(ccpo_pkg::ADDR_FIFO_LVL, h);
        chk(h, 16'h0001);
        rd_reg(ccpo_pkg::ADDR_FIFO_HI, h);
        $display("test stamp done");
    endtask

    // sticky status, enable mask and clear on the interrupt line
    task automatic t_irq();
        logic [15:0] v;
        wr_reg(ccpo_pkg::ADDR_CTRL1, 16'h0011);
        wr_reg(ccpo_pkg::ADDR_IRQ_CLR, 16'h000F);
        wr_reg(ccpo_pkg::ADDR_IRQ_EN, 16'h0001);
        u_ccpo_ext_model.pulse(1, 3, 3);
        repeat (6) @(posedge mclk);
        #1 chk(irq, 1'b1);
        rd_reg(ccpo_pkg::ADDR_FIFO_HI, v);
        wr_reg(ccpo_pkg::ADDR_IRQ_CLR, 16'h0001);
        @(posedge mclk);
        #1 chk(irq, 1'b0);
        wr_reg(ccpo_pkg::ADDR_IRQ_EN, 16'h0000);
        u_ccpo_ext_model.pulse(1, 3, 3);
        repeat (6) @(posedge mclk);
        #1 chk(irq, 1'b0);
        rd_reg(ccpo_pkg::ADDR_STATUS, v);
        chk(v & 16'h0001, 16'h0001);
        rd_reg(ccpo_pkg::ADDR_FIFO_HI, v);
        wr_reg(ccpo_pkg::ADDR_IRQ_CLR, 16'h000F);
        $display("test irq done");
    endtask

    // one-shot length at both ends of the count, both polarities
    task automatic t_oneshot();
        int act;
        for (int k = 0; k < 4; k++)
        begin
            wr_reg(ccpo_pkg::ADDR_CTRL1, 16'h0040);
            wr_reg(ccpo_pkg::ADDR_OUTCTL, ((k[0] ? 16'h7 : 16'h0) << 12) | (16'(k[1]) << 5));
            act = 0;
            fork
                u_ccpo_ext_model.strobe(1'b0);
                repeat (30) @(posedge mclk) #1 act += (out_a_o[0] != k[1]);
            join
            chk(16'(act), k[0] ? 16'h0008 : 16'h0001);
        end
        $display("test oneshot done");
    endtask

    // pins stay undriven until a trigger, then operate
    task automatic t_gate();
        wr_reg(ccpo_pkg::ADDR_CTRL1, 16'h0040);
        wr_reg(ccpo_pkg::ADDR_OUTCTL, 16'h8000);
        repeat (4) @(posedge mclk);
        #1 chk(16'(out_a_oe), 16'h0000);
        u_ccpo_ext_model.strobe(1'b0);
        repeat (3) @(posedge mclk);
        #1 chk(16'(out_a_oe != 3'h0), 16'h0001);
        $display("test gate done");
    endtask

    // shutdown drives active, inactive or releases each group
    task automatic t_shut();
        logic [1:0]  p [3] = '{2'h3, 2'h2, 2'h0};
        logic [15:0] v;
        for (int i = 0; i < 3; i++)
        begin
            wr_reg(ccpo_pkg::ADDR_OUTCTL, {12'h000, p[i], p[i]});
            u_ccpo_ext_model.strobe(1'b1);
            repeat (3) @(posedge mclk);
            #1 chk({4'h0, out_a_oe, out_a_o, out_b_oe, out_b_o},
                   {4'h0, {3{p[i][1]}}, {3{p[i] == 2'h3}},
                          {3{p[i][1]}}, {3{p[i] == 2'h3}}});
            rd_reg(ccpo_pkg::ADDR_STATUS, v);
            chk(v & 16'h0004, 16'h0004);
            wr_reg(ccpo_pkg::ADDR_IRQ_CLR, 16'h0004);
        end
        $display("test shutdown done");
    endtask

    initial
    begin
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        t_reset();
        t_modes();
        t_stamp();
        t_irq();
        t_oneshot();
        t_gate();
        t_shut();
        end_sim();
    end
endmodule
